// ### pcs_params.svh
// Constants for the program counter sequencing and link state block.
`ifndef PCS_PARAMS_SVH
`define PCS_PARAMS_SVH
`define PCS_ADDR_CTRL 32'h0000_0000
`define PCS_ADDR_STAT 32'h0000_0004
`define PCS_ADDR_IRQ_STAT 32'h0000_0008
`define PCS_ADDR_IRQ_MASK 32'h0000_000c
`define PCS_ADDR_RESET_PC 32'h0000_0010
`define PCS_ADDR_EXC_VEC 32'h0000_0014
`define PCS_ADDR_LINK 32'h0000_0018
`define PCS_CTRL_FR_BIT 0
`define PCS_STAT_LL_BIT 0
`define PCS_STAT_ISA_BIT 1
`define PCS_STAT_DS_BIT 2
`define PCS_STAT_FRM_BIT 3
`define PCS_IRQ_EXC_BIT 0
`define PCS_IRQ_SCFAIL_BIT 1
`define PCS_IRQ_W 2
`define PCS_PC_STEP_CMP 32'h0000_0002
`define PCS_PC_STEP_STD 32'h0000_0004
`define PCS_RESET_PC 32'h0000_0000
`define PCS_EXC_VEC 32'h0000_0180
`endif

// ### pcs_pkg.sv
// Types for the program counter sequencing and link state block.
package pcs_pkg;
   typedef enum logic [2:0] {
      PCS_OP_PLAIN,
      PCS_OP_BRANCH,
      PCS_OP_LINKED_LOAD,
      PCS_OP_COND_STORE,
      PCS_OP_STORE,
      PCS_OP_ERET
   } pcs_op_t;
endpackage : pcs_pkg

// ### pcs_core.sv
// Program counter sequencing, link reservation and mode state with an AHB-Lite register slave.
//
// Added by the designer: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/10ps
`default_nettype none
`include "pcs_params.svh"
// Notes on behaviour
// [RULE1] Without a pc write, pc steps by 2 after compressed, else 4.
// [RULE2] A taken branch loads its target during the delay-slot instruction.
// [RULE3] The pc is a full 32-bit address, all bits used for fetch.
// [RULE4] One selector bit: 0 picks 32-bit, 1 picks compressed encodings.
// [RULE5] Link and exception entry store upper pc bits joined with the selector.
// [RULE6] A linked load sets the reservation flag.
// [RULE7] A conditional store succeeds only while the reservation flag is set.
// [RULE8] A store to the reserved location clears the reservation flag.
// [RULE9] Every exception return clears the reservation flag.
// [RULE10] Width select clear: 32x32 registers in pairs; set: 32x64 registers.
// [RULE11] The delay-slot flag follows dynamic execution, false at branch targets.
// [RULE12] An excepting instruction has no further effects and does not resume.
// [RULE13] An instruction's effects land in order within its own instruction time.
// [RULE14] Reset clears the reservation flag so early conditional stores fail.
module pcs_core (
   // Clock and reset.
   input wire logic hclk,
   input wire logic hresetn,
   // AHB-Lite slave.
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // Retire stream from the pipeline.
   input wire logic retire_valid,
   input wire pcs_pkg::pcs_op_t retire_op,
   input wire logic retire_compressed,
   input wire logic branch_taken,
   input wire logic [31:0] branch_target,
   input wire logic branch_link,
   input wire logic target_isa,
   input wire logic [31:0] eret_target,
   input wire logic raise_exception,
   input wire logic [31:0] mem_addr,
   // Sequencing state.
   output logic [31:0] fetch_pc,
   output logic instruction_set_selector,
   output logic in_delay_slot_flag,
   output logic link_reservation_flag,
   output logic fpr_width_mode,
   output logic link_write,
   output logic [31:0] link_value,
   output logic sc_success,
   output logic sc_done,
   output logic exception_taken,
   output logic irq
);
   import pcs_pkg::*;

   logic [31:0] pc_q, pc_d;
   logic isa_q, isa_d;
   logic ds_q, ds_d;
   logic pend_q, pend_d;
   logic [31:0] tgt_q, tgt_d;
   logic tisa_q, tisa_d;
   logic ll_q, ll_d;
   logic [31:0] lladdr_q, lladdr_d;
   logic lw_q, lw_d;
   logic [31:0] lv_q, lv_d;
   logic scs_q, scs_d;
   logic scd_q, scd_d;
   logic exc_q, exc_d;
   logic [31:0] step;
   logic [31:0] ret_pc;

   // Register file state.
   logic fr_q, fr_d;
   logic [`PCS_IRQ_W-1:0] ist_q, ist_d, imask_q, imask_d;
   logic [31:0] rpc_q, rpc_d, evec_q, evec_d;
   logic [31:0] rdata_q, rdata_d;
   logic wpend_q, wpend_d;
   logic [31:0] waddr_q, waddr_d;
   logic [`PCS_IRQ_W-1:0] ev;

   // Returns the link value: upper pc bits with the selector in bit 0.
   function automatic logic [31:0] pcs_link(input logic [31:0] pc, input logic isa);
      pcs_link = {pc[31:1], isa};
   endfunction : pcs_link

   assign step = retire_compressed ? `PCS_PC_STEP_CMP : `PCS_PC_STEP_STD; // RULE1
   // Return address lies beyond the delay slot.
   assign ret_pc = pc_q + `PCS_PC_STEP_STD + step;

   // Next-state logic for the one instruction that may retire in each cycle.
   always_comb begin
      pc_d = pc_q;
      isa_d = isa_q;
      ds_d = ds_q;
      pend_d = pend_q;
      tgt_d = tgt_q;
      tisa_d = tisa_q;
      ll_d = ll_q;
      lladdr_d = lladdr_q;
      lw_d = 1'b0;
      lv_d = lv_q;
      scs_d = 1'b0;
      scd_d = 1'b0;
      exc_d = 1'b0;
      ev = '0;
      if (retire_valid) begin
         if (raise_exception) begin
            // Nothing else of this instruction takes effect.
            // The reservation survives an exception; a return, a conditional store or a store to the reserved word clears it.
            pc_d = evec_q; // RULE12
            pend_d = 1'b0;
            ds_d = 1'b0;
            isa_d = 1'b0;
            exc_d = 1'b1;
            ev[`PCS_IRQ_EXC_BIT] = 1'b1;
            lw_d = 1'b1;
            lv_d = pcs_link(pc_q, isa_q); // RULE5
         end else begin
            // Effects applied in program order within this instruction time.
            unique case (retire_op) // RULE13
               PCS_OP_LINKED_LOAD: begin
                  ll_d = 1'b1; // RULE6
                  lladdr_d = mem_addr;
               end
               PCS_OP_COND_STORE: begin
                  // A conditional store always drops the reservation, pass or fail.
                  scd_d = 1'b1;
                  scs_d = ll_q; // RULE7
                  ev[`PCS_IRQ_SCFAIL_BIT] = ~ll_q;
                  ll_d = 1'b0;
               end
               PCS_OP_STORE: begin
                  // Any store into the reserved word breaks the atomic sequence.
                  if (mem_addr[31:2] == lladdr_q[31:2]) begin
                     ll_d = 1'b0; // RULE8
                  end
               end
               PCS_OP_ERET: begin
                  ll_d = 1'b0; // RULE9
               end
               PCS_OP_BRANCH: begin
                  if (branch_link) begin
                     lw_d = 1'b1;
                     lv_d = pcs_link(ret_pc, isa_q); // RULE5
                  end
               end
               PCS_OP_PLAIN: begin
               end
               default: begin
               end
            endcase
            if (retire_op == PCS_OP_ERET) begin
               pc_d = eret_target;
               isa_d = eret_target[0];
               ds_d = 1'b0;
               pend_d = 1'b0;
            end else if (pend_q) begin
               // The delay-slot instruction is the one that redirects the pc.
               pc_d = tgt_q; // RULE2
               isa_d = tisa_q; // RULE4
               pend_d = 1'b0;
               ds_d = 1'b0; // RULE11
            end else begin
               pc_d = pc_q + step; // RULE1
               ds_d = 1'b0;
            end
            // A branch in the delay slot of a taken branch starts no new redirect.
            if (retire_op == PCS_OP_BRANCH && branch_taken && !pend_q) begin
               pend_d = 1'b1;
               tgt_d = branch_target;
               tisa_d = target_isa;
            end
            // Next instruction is a delay slot only if this one is a branch.
            if (retire_op == PCS_OP_BRANCH && !pend_q) begin
               ds_d = 1'b1; // RULE11
            end
         end
      end
   end

   // Reset leaves the reservation clear so an early conditional store fails.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pc_q <= `PCS_RESET_PC;
         isa_q <= 1'b0;
         ds_q <= 1'b0;
         pend_q <= 1'b0;
         tgt_q <= 32'h0000_0000;
         tisa_q <= 1'b0;
         ll_q <= 1'b0; // RULE14
         lladdr_q <= 32'h0000_0000;
         lw_q <= 1'b0;
         lv_q <= 32'h0000_0000;
         scs_q <= 1'b0;
         scd_q <= 1'b0;
         exc_q <= 1'b0;
      end else begin
         pc_q <= pc_d;
         isa_q <= isa_d;
         ds_q <= ds_d;
         pend_q <= pend_d;
         tgt_q <= tgt_d;
         tisa_q <= tisa_d;
         ll_q <= ll_d;
         lladdr_q <= lladdr_d;
         lw_q <= lw_d;
         lv_q <= lv_d;
         scs_q <= scs_d;
         scd_q <= scd_d;
         exc_q <= exc_d;
      end
   end

   // Bus slave: zero wait states, write data taken in the data phase.
   // Only whole words are decoded; the transfer size is not looked at.
   logic req;
   assign req = hsel && htrans[1] && hready;

   always_comb begin
      fr_d = fr_q;
      imask_d = imask_q;
      rpc_d = rpc_q;
      evec_d = evec_q;
      rdata_d = rdata_q;
      wpend_d = req && hwrite;
      waddr_d = req ? haddr : waddr_q;
      ist_d = ist_q;
      if (wpend_q) begin
         unique case (waddr_q)
            `PCS_ADDR_CTRL: fr_d = hwdata[`PCS_CTRL_FR_BIT];
            `PCS_ADDR_IRQ_STAT: ist_d = ist_q & ~hwdata[`PCS_IRQ_W-1:0];
            `PCS_ADDR_IRQ_MASK: imask_d = hwdata[`PCS_IRQ_W-1:0];
            `PCS_ADDR_RESET_PC: rpc_d = hwdata;
            `PCS_ADDR_EXC_VEC: evec_d = hwdata;
            default: begin
            end
         endcase
      end
      // New events win over a clear in the same cycle.
      ist_d = ist_d | ev;
      // Read data is taken from the next register values, so a read right after
      // a write to the same register already returns the newly written value.
      if (req && !hwrite) begin
         unique case (haddr)
            `PCS_ADDR_CTRL: rdata_d = {31'h0, fr_d};
            `PCS_ADDR_STAT: rdata_d = {28'h0, fr_d, ds_q, isa_q, ll_q};
            `PCS_ADDR_IRQ_STAT: rdata_d = {30'h0, ist_d};
            `PCS_ADDR_IRQ_MASK: rdata_d = {30'h0, imask_d};
            `PCS_ADDR_RESET_PC: rdata_d = rpc_d;
            `PCS_ADDR_EXC_VEC: rdata_d = evec_d;
            `PCS_ADDR_LINK: rdata_d = lv_q;
            default: rdata_d = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         fr_q <= 1'b0;
         ist_q <= '0;
         imask_q <= '0;
         rpc_q <= `PCS_RESET_PC;
         evec_q <= `PCS_EXC_VEC;
         rdata_q <= 32'h0000_0000;
         wpend_q <= 1'b0;
         waddr_q <= 32'h0000_0000;
      end else begin
         fr_q <= fr_d;
         ist_q <= ist_d;
         imask_q <= imask_d;
         rpc_q <= rpc_d;
         evec_q <= evec_d;
         rdata_q <= rdata_d;
         wpend_q <= wpend_d;
         waddr_q <= waddr_d;
      end
   end

   assign hrdata = rdata_q;
   // The slave never stalls and always answers OKAY.
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign fetch_pc = pc_q; // RULE3
   assign instruction_set_selector = isa_q; // RULE4
   assign in_delay_slot_flag = ds_q;
   assign link_reservation_flag = ll_q;
   assign fpr_width_mode = fr_q; // RULE10
   assign link_write = lw_q;
   assign link_value = lv_q;
   assign sc_success = scs_q;
   assign sc_done = scd_q;
   assign exception_taken = exc_q;
   // Level interrupt, high while any unmasked status bit is set.
   assign irq = |(ist_q & imask_q);
endmodule : pcs_core
`default_nettype wire

// ### pcs_mem_model.sv
// Far-side model that takes the return address the core hands out.
`timescale 1ns/10ps
`default_nettype none
module pcs_mem_model (
   // Clock and reset.
   input wire logic hclk,
   input wire logic hresetn,
   // Link write port.
   input wire logic link_write,
   input wire logic [31:0] link_value,
   output logic [31:0] last_link
);
   // Stands in for the register file port that receives the link value.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) last_link <= 32'h0;
      else if (link_write) last_link <= link_value;
   end
endmodule : pcs_mem_model
`default_nettype wire

// ### pcs_checker.sv
// Concurrent checks on the retire side of the sequencing block.
`timescale 1ns/10ps
`default_nettype none
`include "pcs_params.svh"
module pcs_checker (
   // Clock and reset.
   input wire logic hclk,
   input wire logic hresetn,
   // Retire stream.
   input wire logic retire_valid,
   input wire logic retire_compressed,
   input wire logic branch_taken,
   input wire logic branch_link,
   input wire pcs_pkg::pcs_op_t retire_op,
   input wire logic [31:0] eret_target,
   input wire logic raise_exception,
   // Sequencing state.
   input wire logic [31:0] fetch_pc,
   input wire logic [31:0] link_value,
   input wire logic instruction_set_selector,
   input wire logic in_delay_slot_flag,
   input wire logic link_reservation_flag,
   input wire logic link_write,
   input wire logic sc_success,
   input wire logic sc_done,
   input wire logic exception_taken
);
   import pcs_pkg::*;
   wire logic ok = retire_valid && !raise_exception;
   wire logic eret_isa = eret_target[0];
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   AST_PC_STEP: assert property (ok && retire_op == PCS_OP_PLAIN && !in_delay_slot_flag
      |=> fetch_pc == $past(fetch_pc) + ($past(retire_compressed) ? 32'h2 : 32'h4))
      else $error("pc step wrong");
   AST_BR_SLOT: assert property (ok && retire_op == PCS_OP_BRANCH && branch_taken
      && !in_delay_slot_flag |=> in_delay_slot_flag
      && fetch_pc == $past(fetch_pc) + ($past(retire_compressed) ? 32'h2 : 32'h4))
      else $error("branch redirected too early");
   AST_DS_CLR: assert property (ok && in_delay_slot_flag |=> !in_delay_slot_flag)
      else $error("delay slot flag stuck");
   AST_LL_SET: assert property (ok && retire_op == PCS_OP_LINKED_LOAD |=> link_reservation_flag)
      else $error("reservation not set");
   AST_SC_TEST: assert property (ok && retire_op == PCS_OP_COND_STORE |=> sc_done
      && sc_success == $past(link_reservation_flag) && !link_reservation_flag)
      else $error("conditional store result wrong");
   AST_ERET_CLR: assert property (ok && retire_op == PCS_OP_ERET |=> !link_reservation_flag
      && instruction_set_selector == $past(eret_isa)) else $error("return state wrong");
   AST_EXC: assert property (retire_valid && raise_exception |=> exception_taken
      && fetch_pc == `PCS_EXC_VEC && !in_delay_slot_flag && link_write
      && link_value[0] == $past(instruction_set_selector)
      && link_reservation_flag == $past(link_reservation_flag)) else $error("exception effects");
   AST_LINK: assert property (ok && retire_op == PCS_OP_BRANCH && branch_link |=> link_write
      && link_value[0] == $past(instruction_set_selector)) else $error("link value wrong");
   AST_IDLE: assert property (!retire_valid |=> $stable(fetch_pc)
      && $stable(link_reservation_flag)) else $error("state moved without retire");
endmodule : pcs_checker
bind pcs_core pcs_checker u_pcs_checker (.*);
`default_nettype wire

// ### tb_top.sv
// Self-checking bench for the sequencing block.
`timescale 1ns/10ps
`default_nettype none
`include "pcs_params.svh"
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin errors++; $display("ERROR %0t mismatch", $time); end end
module tb_top;
   import pcs_pkg::*;
   logic hclk = '0, hresetn = '0, hsel = '0, hwrite = '0, retire_valid = '0, retire_compressed = '0;
   logic branch_taken = '0, branch_link = '0, target_isa = '0, raise_exception = '0;
   logic [1:0] htrans = '0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] haddr = '0, hwdata = '0, branch_target = '0, eret_target = '0, mem_addr = '0, r;
   pcs_op_t retire_op = PCS_OP_PLAIN;
   logic [31:0] hrdata, fetch_pc, link_value, last_link;
   logic hreadyout, hresp, instruction_set_selector, in_delay_slot_flag, link_reservation_flag;
   logic fpr_width_mode, link_write, sc_success, sc_done, exception_taken, irq;
   int errors = 0, n_checks = 0, cyc = 0;
   pcs_core u_pcs_core (.hready(hreadyout), .*);
   pcs_mem_model u_pcs_mem_model (.*);
   initial forever #12.5 hclk = ~hclk;
   always @(posedge hclk) begin
      cyc++;
      if (cyc == 3000) begin
         errors++;
         results();
      end
   end
   task ahb(input logic w, input logic [31:0] a, d);
      @(posedge hclk);
      hsel <= 1'h1; htrans <= 2'h2; haddr <= a; hwrite <= w;
      @(posedge hclk);
      while (hreadyout !== 1'h1) @(posedge hclk);
      hsel <= 1'h0; htrans <= 2'h0; hwdata <= d;
      @(posedge hclk);
      while (hreadyout !== 1'h1) @(posedge hclk);
      r = hrdata;
      `CHK(hresp, 1'h0)
      #1;
   endtask : ahb
   task ret(input pcs_op_t op, input logic c, ex, tk, lk, input logic [31:0] a);
      @(posedge hclk);
      retire_valid <= 1'h1; retire_op <= op; retire_compressed <= c; raise_exception <= ex;
      branch_taken <= tk; branch_link <= lk; branch_target <= a; eret_target <= a; mem_addr <= a;
      @(posedge hclk);
      retire_valid <= 1'h0;
      #1;
   endtask : ret
   task t_llsc;
      ret(PCS_OP_COND_STORE, 0, 0, 0, 0, 32'h40);
      `CHK(sc_success, 1'h0)
      ret(PCS_OP_LINKED_LOAD, 0, 0, 0, 0, 32'h40);
      `CHK(link_reservation_flag, 1'h1)
      ret(PCS_OP_COND_STORE, 0, 0, 0, 0, 32'h40);
      `CHK(sc_success, 1'h1)
      ret(PCS_OP_LINKED_LOAD, 0, 0, 0, 0, 32'h40);
      ret(PCS_OP_STORE, 0, 0, 0, 0, 32'h80);
      `CHK(link_reservation_flag, 1'h1)
      ret(PCS_OP_STORE, 0, 0, 0, 0, 32'h42);
      `CHK(link_reservation_flag, 1'h0)
      ret(PCS_OP_LINKED_LOAD, 0, 0, 0, 0, 32'h40);
      ret(PCS_OP_ERET, 0, 0, 0, 0, 32'h0);
      `CHK(link_reservation_flag, 1'h0)
   endtask : t_llsc
   task t_step;
      ret(PCS_OP_ERET, 0, 0, 0, 0, 32'h8000_0000);
      `CHK(fetch_pc, 32'h8000_0000)
      ret(PCS_OP_PLAIN, 1, 0, 0, 0, 32'h0);
      `CHK(fetch_pc, 32'h8000_0002)
      ret(PCS_OP_PLAIN, 0, 0, 0, 0, 32'h0);
      `CHK(fetch_pc, 32'h8000_0006)
   endtask : t_step
   task t_branch;
      ret(PCS_OP_ERET, 0, 0, 0, 0, 32'h100);
      ret(PCS_OP_BRANCH, 0, 0, 1, 0, 32'h200);
      `CHK(fetch_pc, 32'h104)
      `CHK(in_delay_slot_flag, 1'h1)
      ret(PCS_OP_BRANCH, 0, 0, 1, 0, 32'h300);
      `CHK(fetch_pc, 32'h200)
      `CHK(in_delay_slot_flag, 1'h0)
      ret(PCS_OP_PLAIN, 0, 0, 0, 0, 32'h0);
      `CHK(fetch_pc, 32'h204)
   endtask : t_branch
   task t_link;
      ret(PCS_OP_ERET, 0, 0, 0, 0, 32'h401);
      `CHK(instruction_set_selector, 1'h1)
      ret(PCS_OP_BRANCH, 0, 0, 0, 1, 32'h0);
      `CHK(link_write, 1'h1)
      `CHK(link_value, 32'h0000_0409)
      @(posedge hclk);
      #1;
      `CHK(last_link[0], 1'h1)
      ret(PCS_OP_PLAIN, 0, 0, 0, 0, 32'h0);
      ret(PCS_OP_ERET, 0, 0, 0, 0, 32'h0);
      `CHK(instruction_set_selector, 1'h0)
   endtask : t_link
   task t_exc;
      ahb(1, `PCS_ADDR_IRQ_MASK, 32'h1);
      `CHK(irq, 1'h0)
      ret(PCS_OP_LINKED_LOAD, 0, 0, 0, 0, 32'h40);
      ret(PCS_OP_PLAIN, 0, 1, 0, 0, 32'h0);
      `CHK(fetch_pc, `PCS_EXC_VEC)
      `CHK(link_reservation_flag, 1'h1)
      `CHK(irq, 1'h1)
      ahb(1, `PCS_ADDR_IRQ_STAT, 32'h1);
      `CHK(irq, 1'h0)
      ahb(0, `PCS_ADDR_IRQ_STAT, 32'h0);
      `CHK(r, 32'h2)
      ret(PCS_OP_ERET, 0, 0, 0, 0, 32'h0);
      ret(PCS_OP_LINKED_LOAD, 0, 1, 0, 0, 32'h40);
      `CHK(link_reservation_flag, 1'h0)
      ahb(1, `PCS_ADDR_IRQ_MASK, 32'h0);
      `CHK(irq, 1'h0)
   endtask : t_exc
   task t_regs;
      ahb(1, `PCS_ADDR_CTRL, 32'h1);
      `CHK(fpr_width_mode, 1'h1)
      ahb(0, `PCS_ADDR_STAT, 32'h0);
      `CHK(r[3], 1'h1)
      ahb(0, 32'h40, 32'h0);
      `CHK(r, 32'h0)
      ahb(1, `PCS_ADDR_CTRL, 32'h0);
      `CHK(fpr_width_mode, 1'h0)
   endtask : t_regs
   task t_reset;
      ret(PCS_OP_LINKED_LOAD, 0, 0, 0, 0, 32'h40);
      `CHK(link_reservation_flag, 1'h1)
      hresetn <= 1'h0;
      repeat (2) @(posedge hclk);
      `CHK(link_reservation_flag, 1'h0)
      hresetn <= 1'h1;
      ret(PCS_OP_COND_STORE, 0, 0, 0, 0, 32'h40);
      `CHK(sc_success, 1'h0)
      `CHK(fetch_pc, `PCS_RESET_PC + 32'h4)
   endtask : t_reset
   task results;
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : results
   initial begin
      repeat (20) @(posedge hclk);
      hresetn <= 1'h1;
      t_llsc();
      t_step();
      t_branch();
      t_link();
      t_exc();
      t_regs();
      t_reset();
      results();
   end
endmodule : tb_top
`default_nettype wire
